// ===== corr_inject.sv
`timescale 1ns/1ps
// one-shot trigger pulses toward the correctable error status register
module corr_inject
(
	input wire logic sys_clk_in,
	input wire logic rstn_in,
	input wire logic write_in,
	input wire logic [31:0] wdata_in,
	input wire logic [3:0] byte_en_in,
	output logic [31:0] set_pulse_out
);
	logic [31:0] lane_mask;
	logic [31:0] next_pulse;

	assign lane_mask = {{8{byte_en_in[3]}}, {8{byte_en_in[2]}}, {8{byte_en_in[1]}},
		{8{byte_en_in[0]}}};
	// reserved bits never reach the status register
	assign next_pulse = write_in ? (wdata_in & lane_mask & errinj_pkg::CORR_TRIGGER_MASK)
		: errinj_pkg::RESET_VALUE;

	always_ff @(posedge sys_clk_in)
	begin
		if (!rstn_in)
			set_pulse_out <= errinj_pkg::RESET_VALUE;
		else
			set_pulse_out <= next_pulse;
	end
endmodule

// ===== errinj_pkg.sv
// shared constants and carrier types for the error inject and indirect access block
package errinj_pkg;
	localparam logic [11:0] CORR_INJECT_OFFSET = 12'hD94;
	localparam logic [11:0] GLOBAL_ADDR_OFFSET = 12'hFF8;
	localparam logic [11:0] GLOBAL_DATA_OFFSET = 12'hFFC;
	localparam int RECEIVER_ERROR_POS = 0;
	localparam int BAD_PACKET_POS = 6;
	localparam int BAD_LINK_PACKET_POS = 7;
	localparam int REPLAY_ROLLOVER_POS = 8;
	localparam int REPLAY_TIMEOUT_POS = 12;
	localparam int INTERNAL_ERROR_POS = 14;
	localparam int HEADER_LOG_FULL_POS = 15;
	localparam logic [31:0] CORR_TRIGGER_MASK = 32'h0000D1C1;
	localparam int TARGET_LSB = 2;
	localparam int TARGET_MSB = 18;
	localparam logic [31:0] GLOBAL_ADDR_MASK = 32'h0007FFFC;
	localparam logic [31:0] RESET_VALUE = 32'h00000000;
	localparam int GLOBAL_LATENCY = 1;

	// one configuration or sideband access, valid for one cycle
	typedef struct packed
	{
		logic valid;
		logic write;
		logic from_smbus;
		logic [11:0] offset;
		logic [3:0] byte_en;
		logic [31:0] wdata;
	} cfg_req_t;

	typedef struct packed
	{
		logic valid;
		logic write;
		logic [16:0] target;
		logic [3:0] byte_en;
		logic [31:0] wdata;
	} global_req_t;
endpackage

// ===== errinj_properties.sv
// port assertions for the inject and window block
`timescale 1ns/1ps
module errinj_properties
(
	input wire logic sys_clk_in,
	input wire logic rstn_in,
	input wire errinj_pkg::cfg_req_t req_in,
	input wire logic rsp_valid_out,
	input wire logic [31:0] rsp_rdata_out,
	input wire errinj_pkg::global_req_t global_req_out,
	input wire logic global_rsp_valid_in,
	input wire logic [31:0] global_rsp_rdata_in,
	input wire logic [31:0] corr_status_set_out
);
	default clocking @(posedge sys_clk_in);
	endclocking
	default disable iff (!rstn_in);
	logic rd;
	wire inj = req_in.valid && req_in.offset == errinj_pkg::CORR_INJECT_OFFSET;
	wire dat = req_in.valid && req_in.offset == errinj_pkg::GLOBAL_DATA_OFFSET;
	always_ff @(posedge sys_clk_in)
		if (global_req_out.valid)
			rd <= !global_req_out.write;
	chk_inject_sets_bits: assert property (
		inj && req_in.write && req_in.byte_en == 4'hF |=>
		corr_status_set_out == ($past(req_in.wdata) & errinj_pkg::CORR_TRIGGER_MASK))
		else $error("inject");
	chk_inject_one_shot: assert property (corr_status_set_out != 32'h0 |-> $past(inj))
		else $error("pulse");
	chk_inject_reads_zero: assert property (inj && !req_in.write |=> rsp_rdata_out == 32'h0)
		else $error("inject read");
	chk_reserved_quiet: assert property (
		(corr_status_set_out & ~errinj_pkg::CORR_TRIGGER_MASK) == 32'h0)
		else $error("reserved");
	chk_window_forward: assert property (
		dat && !req_in.from_smbus |=> global_req_out.valid &&
		global_req_out.byte_en == $past(req_in.byte_en) && global_req_out.write == $past(req_in.write)
		&& (!global_req_out.write || global_req_out.wdata == $past(req_in.wdata)))
		else $error("forward");
	chk_read_return: assert property (
		global_rsp_valid_in && rd |=> rsp_valid_out && rsp_rdata_out == $past(global_rsp_rdata_in))
		else $error("return");
	chk_smbus_inert: assert property (
		dat && req_in.from_smbus |=> rsp_valid_out && rsp_rdata_out == 32'h0 && !global_req_out.valid)
		else $error("smbus");
	chk_window_cause: assert property (
		global_req_out.valid |-> $past(dat && !req_in.from_smbus))
		else $error("cause");
endmodule
bind error_inject_and_indirect_access errinj_properties i_props (.sys_clk_in(sys_clk_in),
	.rstn_in(rstn_in), .req_in(req_in), .rsp_valid_out(rsp_valid_out),
	.rsp_rdata_out(rsp_rdata_out), .global_req_out(global_req_out),
	.global_rsp_valid_in(global_rsp_valid_in), .global_rsp_rdata_in(global_rsp_rdata_in),
	.corr_status_set_out(corr_status_set_out));

// ===== error_inject_and_indirect_access.sv
`timescale 1ns/1ps
// bridge function register extension: correctable error injection and global window
//
// Contract
// - writing one to bit 0 sets receiver error status bit.
// - writing one to bit 6 sets bad packet status bit.
// - writing one to bit 7 sets bad link packet status bit.
// - writing one to bit 8 sets replay rollover status bit.
// - writing one to bit 12 sets replay timeout status bit.
// - writing one to bit 14 sets internal error status bit.
// - writing one to bit 15 sets header log overflow status bit.
// - trigger register always reads zero; writes are one-shot pulses.
// - address register bits 18:2 hold the global target address.
// - data register read returns selected global register contents.
// - data register write updates the selected global register.
// - window byte enables equal those of the data register access.
// - sideband data register reads return zero; sideband writes do nothing.
module error_inject_and_indirect_access
(
	input wire logic sys_clk_in,
	input wire logic rstn_in,
	input wire errinj_pkg::cfg_req_t req_in,
	output logic rsp_valid_out,
	output logic [31:0] rsp_rdata_out,
	output errinj_pkg::global_req_t global_req_out,
	input wire logic global_rsp_valid_in,
	input wire logic [31:0] global_rsp_rdata_in,
	output logic [31:0] corr_status_set_out
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef enum logic [1:0]
	{
		IDLE = 2'b00,
		WAIT_GLOBAL = 2'b01
	} state_t;

	state_t state;
	state_t next_state;
	logic [16:0] target;
	logic hit_inject;
	logic hit_addr;
	logic hit_data;
	logic local_done;
	logic go_global;
	logic [31:0] local_rdata;
	logic next_rsp_valid;
	logic [31:0] next_rsp_rdata;
	errinj_pkg::global_req_t next_global_req;

	// ----------------------------------------
	// decode
	// ----------------------------------------
	assign hit_inject = req_in.offset == errinj_pkg::CORR_INJECT_OFFSET;
	assign hit_addr = req_in.offset == errinj_pkg::GLOBAL_ADDR_OFFSET;
	assign hit_data = req_in.offset == errinj_pkg::GLOBAL_DATA_OFFSET;
	// only host accesses of the data register go out; sideband ones stay local
	assign go_global = state == IDLE && req_in.valid && hit_data && !req_in.from_smbus;
	assign local_done = state == IDLE && req_in.valid && !go_global;
	// inject reads zero, data over sideband reads zero, unmapped reads zero
	assign local_rdata = hit_addr ? {13'h0000, target, 2'h0}
		: errinj_pkg::RESET_VALUE;

	// ----------------------------------------
	// register parts
	// ----------------------------------------
	corr_inject u_inject
	(
		.sys_clk_in(sys_clk_in),
		.rstn_in(rstn_in),
		.write_in(local_done && req_in.write && hit_inject),
		.wdata_in(req_in.wdata),
		.byte_en_in(req_in.byte_en),
		.set_pulse_out(corr_status_set_out)
	);

	global_addr_reg u_addr
	(
		.sys_clk_in(sys_clk_in),
		.rstn_in(rstn_in),
		.write_in(local_done && req_in.write && hit_addr),
		.wdata_in(req_in.wdata),
		.byte_en_in(req_in.byte_en),
		.target_out(target)
	);

	// ----------------------------------------
	// window sequencing
	// ----------------------------------------
	// one access in flight; requests arriving while waiting are not taken
	always_comb
	begin
		next_state = state;
		next_rsp_valid = 1'b0;
		next_rsp_rdata = errinj_pkg::RESET_VALUE;
		next_global_req = '0;
		case (state)
			IDLE:
			begin
				if (go_global)
				begin
					next_state = WAIT_GLOBAL;
					next_global_req.valid = 1'b1;
					next_global_req.write = req_in.write;
					next_global_req.target = target;
					next_global_req.byte_en = req_in.byte_en;
					next_global_req.wdata = req_in.wdata;
				end
				else if (local_done)
				begin
					next_rsp_valid = 1'b1;
					next_rsp_rdata = req_in.write ? errinj_pkg::RESET_VALUE : local_rdata;
				end
			end
			WAIT_GLOBAL:
			begin
				if (global_rsp_valid_in)
				begin
					next_state = IDLE;
					next_rsp_valid = 1'b1;
					next_rsp_rdata = global_rsp_rdata_in;
				end
			end
			default:
				next_state = IDLE;
		endcase
	end

	always_ff @(posedge sys_clk_in)
	begin
		if (!rstn_in)
		begin
			state <= IDLE;
			rsp_valid_out <= 1'b0;
			rsp_rdata_out <= errinj_pkg::RESET_VALUE;
			global_req_out <= '0;
		end
		else
		begin
			state <= next_state;
			rsp_valid_out <= next_rsp_valid;
			rsp_rdata_out <= next_rsp_rdata;
			global_req_out <= next_global_req;
		end
	end
endmodule

// ===== error_inject_and_indirect_access_tb.sv
// self-checking bench for the inject and window block
`timescale 1ns/1ps
module error_inject_and_indirect_access_tb;
	logic sys_clk_in = 1'b0;
	logic rstn_in = 1'b0;
	logic rv, grv;
	logic [31:0] rdata, grd, cs, rd, sv;
	logic [3:0] dly = 4'h0;
	errinj_pkg::cfg_req_t req = '0;
	errinj_pkg::global_req_t greq;
	int errors = 0;
	int check_count = 0;
	int pos[7] = '{0, 6, 7, 8, 12, 14, 15};
	error_inject_and_indirect_access i_dut (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
		.req_in(req), .rsp_valid_out(rv), .rsp_rdata_out(rdata), .global_req_out(greq),
		.global_rsp_valid_in(grv), .global_rsp_rdata_in(grd), .corr_status_set_out(cs));
	global_space_model i_space (.sys_clk_in(sys_clk_in), .delay_in(dly), .req_in(greq),
		.rsp_valid_out(grv), .rsp_rdata_out(grd));
	initial forever #25 sys_clk_in = ~sys_clk_in;
	task automatic finish_test();
		if (errors == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e)
		begin
			errors++;
			$display("CHECK FAILED %0t %h %h", $time, s, e);
		end
	endtask
	task automatic acc(input logic w, input logic m, input logic [11:0] o,
		input logic [3:0] b, input logic [31:0] d);
		int k = 0;
		req <= '{1'b1, w, m, o, b, d};
		@(posedge sys_clk_in);
		req.valid <= 1'b0;
		#1;
		sv = cs;
		while (rv !== 1'b1 && k++ < 40)
			@(posedge sys_clk_in) #1;
		// a missing answer counts against the run
		if (rv !== 1'b1)
			errors++;
		rd = rdata;
		@(posedge sys_clk_in);
	endtask
	initial
	begin
		#200000;
		errors++;
		finish_test();
	end
	initial
	begin
		repeat (6) @(posedge sys_clk_in);
		rstn_in <= 1'b1;
		@(posedge sys_clk_in);
		acc(1'b0, 1'b0, 12'hFF8, 4'hF, 32'h0);
		chk(rd, 32'h0);
		foreach (pos[i])
		begin
			acc(1'b1, 1'b0, 12'hD94, 4'hF, 32'h1 << pos[i]);
			chk(sv, 32'h1 << pos[i]);
		end
		acc(1'b1, 1'b0, 12'hD94, 4'h1, 32'hFFFFFFFF);
		chk(sv, 32'h000000C1);
		acc(1'b0, 1'b0, 12'hD94, 4'hF, 32'h0);
		chk(rd, 32'h0);
		acc(1'b1, 1'b0, 12'hFF8, 4'hF, 32'hFFFFFFFF);
		acc(1'b0, 1'b0, 12'hFF8, 4'hF, 32'h0);
		chk(rd, 32'h0007FFFC);
		acc(1'b1, 1'b0, 12'hFF8, 4'hF, 32'h00000010);
		acc(1'b1, 1'b0, 12'hFFC, 4'hF, 32'hA5A5A5A5);
		dly <= 4'h3;
		acc(1'b1, 1'b0, 12'hFFC, 4'h2, 32'h00003C00);
		acc(1'b1, 1'b1, 12'hFFC, 4'hF, 32'hFFFFFFFF);
		acc(1'b0, 1'b1, 12'hFFC, 4'hF, 32'h0);
		chk(rd, 32'h0);
		acc(1'b0, 1'b0, 12'hFFC, 4'hF, 32'h0);
		chk(rd, 32'hA5A53CA5);
		acc(1'b0, 1'b0, 12'h100, 4'hF, 32'h0);
		chk(rd, 32'h0);
		finish_test();
	end
endmodule

// ===== global_addr_reg.sv
`timescale 1ns/1ps
// target address holder for the indirect global window
module global_addr_reg
(
	input wire logic sys_clk_in,
	input wire logic rstn_in,
	input wire logic write_in,
	input wire logic [31:0] wdata_in,
	input wire logic [3:0] byte_en_in,
	output logic [16:0] target_out
);
	logic [31:0] merged;
	logic [31:0] current;

	assign current = {13'h0000, target_out, 2'h0};
	assign merged = {byte_en_in[3] ? wdata_in[31:24] : current[31:24],
		byte_en_in[2] ? wdata_in[23:16] : current[23:16],
		byte_en_in[1] ? wdata_in[15:8] : current[15:8],
		byte_en_in[0] ? wdata_in[7:0] : current[7:0]};

	always_ff @(posedge sys_clk_in)
	begin
		if (!rstn_in)
			target_out <= 17'h00000;
		else if (write_in)
			target_out <= merged[errinj_pkg::TARGET_MSB:errinj_pkg::TARGET_LSB];
	end
endmodule

// ===== global_space_model.sv
// behavioural global register space behind the window
`timescale 1ns/1ps
module global_space_model
(
	input wire logic sys_clk_in,
	input wire logic [3:0] delay_in,
	input wire errinj_pkg::global_req_t req_in,
	output logic rsp_valid_out,
	output logic [31:0] rsp_rdata_out
);
	logic [31:0] mem [16];
	logic [31:0] q;
	int n = -1;
	initial rsp_valid_out = 1'b0;
	// data inverts when idle so a stale word never passes for an answer
	always @(posedge sys_clk_in)
	begin
		rsp_valid_out <= 1'b0;
		rsp_rdata_out <= ~q;
		if (req_in.valid)
		begin
			n = delay_in;
			q = mem[req_in.target[3:0]];
			for (int b = 0; b < 4; b++)
				if (req_in.write && req_in.byte_en[b])
					mem[req_in.target[3:0]][8*b+:8] = req_in.wdata[8*b+:8];
		end
		if (n == 0)
		begin
			rsp_valid_out <= 1'b1;
			rsp_rdata_out <= q;
		end
		if (n >= 0)
			n--;
	end
endmodule
